// ===== bench/ext_source_model.sv
// External interrupt sources and cascaded slave controller model
module ext_source_model (
  // Clock and reset
  input  wire logic       clock_i,
  input  wire logic       arst_n_i,
  // Bench stimulus
  input  wire logic [3:0] want_i,
  input  wire logic [7:0] slave_vec_i,
  // Acknowledge lines at wire level
  input  wire logic       ack_zero_n_i,
  input  wire logic       ack_one_n_i,
  // Toward the controller
  output logic      [3:0] pin_o,
  output logic      [7:0] cas_vec_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] served_ff;
  logic [7:0] junk_ff;
  ////////////////////////////////////////////////////////////////////////////////
  // request held until own acknowledge line seen low
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      served_ff <= 2'h0;
      junk_ff   <= 8'h5a;
    end else begin
      served_ff[0] <= want_i[0] & (served_ff[0] | ~ack_zero_n_i);
      served_ff[1] <= want_i[1] & (served_ff[1] | ~ack_one_n_i);
      junk_ff      <= junk_ff + 8'h3b;
    end
  end
  assign pin_o = want_i & {2'h3, ~served_ff};
  // vector only while acknowledged; a moving pattern otherwise
  assign cas_vec_o = (!ack_zero_n_i || !ack_one_n_i) ? slave_vec_i : junk_ff;
endmodule : ext_source_model

// ===== bench/priority_interrupt_controller_tb.sv
// Self-checking bench of the priority interrupt controller
module priority_interrupt_controller_tb;
  import pic_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic [7:0]  a;
    logic [15:0] d;
  } row_t;
  logic        clk = 1'b0;
  logic        arst_n = 1'b0;
  logic [7:0]  addr = 8'h00;
  logic [15:0] wdata = 16'h0000;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic [2:0]  tmr = 3'h0;
  logic [1:0]  dma = 2'h0;
  logic        inta = 1'b0;
  logic [3:0]  want = 4'h0;
  logic [7:0]  svec = 8'h00;
  logic [15:0] rdata;
  logic [7:0]  vec;
  logic [7:0]  cvec;
  logic [3:0]  pins;
  logic        intr, vvalid, a0_o, a0_oe, a1_o, a1_oe;
  wire logic   ack0_n = a0_oe ? a0_o : 1'b1;
  wire logic   ack1_n = a1_oe ? a1_o : 1'b1;
  wire logic   pin2w  = a0_oe ? a0_o : pins[2];
  wire logic   pin3w  = a1_oe ? a1_o : pins[3];
  int          err_count = 0;
  int          checks_done = 0;
  int          cycles = 0;
  // Reset values, an unmapped place and the write-only command place
  localparam row_t rows [11] = '{
    '{8'h28, 16'h00fd}, '{8'h2a, 16'h0007}, '{8'h2c, 16'h0000}, '{8'h2e, 16'h0000},
    '{8'h30, 16'h0000}, '{8'h32, 16'h000f}, '{8'h34, 16'h000f}, '{8'h38, 16'h000f},
    '{8'h3e, 16'h000f}, '{8'h22, 16'h0000}, '{8'h40, 16'h0000}};

  always #2.5 clk = ~clk;

  priority_interrupt_controller u_dut (
    .CLOCK_I(clk), .ARST_N_I(arst_n), .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr),
    .RD_I(rd), .RDATA_O(rdata), .TIMER_REQ_I(tmr), .DMA_REQ_I(dma), .INTA_I(inta),
    .INTR_O(intr), .VECTOR_O(vec), .VECTOR_VALID_O(vvalid),
    .EXT_REQUEST_ZERO_I(pins[0]), .EXT_REQUEST_ONE_I(pins[1]),
    .EXT_PIN_TWO_OR_ACK_ZERO_I(pin2w), .EXT_PIN_TWO_OR_ACK_ZERO_O(a0_o),
    .EXT_PIN_TWO_OR_ACK_ZERO_OE_O(a0_oe), .EXT_PIN_THREE_OR_ACK_ONE_I(pin3w),
    .EXT_PIN_THREE_OR_ACK_ONE_O(a1_o), .EXT_PIN_THREE_OR_ACK_ONE_OE_O(a1_oe),
    .CAS_VECTOR_I(cvec));

  ext_source_model u_src (
    .clock_i(clk), .arst_n_i(arst_n), .want_i(want), .slave_vec_i(svec),
    .ack_zero_n_i(ack0_n), .ack_one_n_i(ack1_n), .pin_o(pins), .cas_vec_o(cvec));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic results;
    if (err_count == 0 && checks_done > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : results

  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    checks_done++;
    if (g !== e) begin
      err_count++;
      $display("[FAIL] %0t got %h expected %h", $time, g, e);
    end
  endtask : chk

  task automatic wrr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
  endtask : wrr

  task automatic rdc(input logic [7:0] a, input logic [15:0] e);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    #1 chk(rdata, e);
  endtask : rdc

  task automatic pulse(input logic [1:0] d, input logic [2:0] t);
    @(posedge clk);
    dma <= d;
    tmr <= t;
    @(posedge clk);
    dma <= 2'h0;
    tmr <= 3'h0;
  endtask : pulse

  // Bounded wait; resolution is combinational so a few cycles suffice
  task automatic wait_intr(input logic e);
    int n;
    n = 0;
    #1;
    while (intr !== e && n < 10) begin
      @(posedge clk);
      #1 n++;
    end
    chk({15'h0000, intr}, {15'h0000, e});
  endtask : wait_intr

  // Two acknowledge pulses; ln is the expected pair of acknowledge lines
  task automatic ack(input logic [7:0] v, input logic [1:0] ln);
    @(posedge clk);
    inta <= 1'b1;
    @(posedge clk);
    inta <= 1'b0;
    #1 chk({14'h0000, ack1_n, ack0_n}, {14'h0000, ln});
    repeat (4) @(posedge clk);
    inta <= 1'b1;
    @(posedge clk);
    inta <= 1'b0;
    #1 chk({15'h0000, vvalid}, 16'h0001);
    chk({8'h00, vec}, {8'h00, v});
    chk({14'h0000, ack1_n, ack0_n}, 16'h0003);
  endtask : ack

  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      err_count++;
      $display("[FAIL] %0t run did not complete", $time);
      results();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (10) @(posedge clk);
    arst_n <= 1'b1;
    for (int i = 0; i < 11; i++) begin
      rdc(rows[i].a, rows[i].d);
    end
    // Timer event: status bit and OR in request word
    pulse(2'h0, 3'h2);
    rdc(8'h30, 16'h0002);
    rdc(8'h2e, 16'h0001);
    wrr(8'h30, 16'h0000);
    // Shared mask storage
    wrr(8'h28, 16'h00f1);
    rdc(8'h34, 16'h0007);
    rdc(8'h3c, 16'h000f);
    // Tie at one level, poll status then poll
    wrr(8'h34, 16'h0002);
    wrr(8'h36, 16'h0002);
    pulse(2'h3, 3'h0);
    wait_intr(1'b1);
    rdc(8'h2e, 16'h000c);
    rdc(8'h26, 16'h800a);
    rdc(8'h2c, 16'h0000);
    rdc(8'h24, 16'h800a);
    rdc(8'h2c, 16'h0004);
    wait_intr(1'b0);
    rdc(8'h26, 16'h000b);
    wrr(8'h22, 16'h8000);
    wait_intr(1'b1);
    wrr(8'h2a, 16'h0001);
    wait_intr(1'b0);
    wrr(8'h2a, 16'h0002);
    wait_intr(1'b1);
    rdc(8'h24, 16'h800b);
    wrr(8'h2c, 16'h000c);
    wrr(8'h22, 16'h000a);
    rdc(8'h2c, 16'h0008);
    wrr(8'h22, 16'h8000);
    rdc(8'h2c, 16'h0000);
    // Edge-triggered pin two
    wrr(8'h3c, 16'h0001);
    want[2] <= 1'b1;
    wait_intr(1'b1);
    rdc(8'h2e, 16'h0040);
    ack(8'h0e, 2'h3);
    rdc(8'h2c, 16'h0040);
    wrr(8'h22, 16'h000e);
    repeat (6) @(posedge clk);
    #1 chk({15'h0000, intr}, 16'h0000);
    rdc(8'h2e, 16'h0000);
    want[2] <= 1'b0;
    repeat (3) @(posedge clk);
    want[2] <= 1'b1;
    wait_intr(1'b1);
    ack(8'h0e, 2'h3);
    wrr(8'h22, 16'h8000);
    want[2] <= 1'b0;
    // Level-triggered pin three
    wrr(8'h3e, 16'h0011);
    want[3] <= 1'b1;
    wait_intr(1'b1);
    ack(8'h0f, 2'h3);
    wait_intr(1'b0);
    wrr(8'h22, 16'h000f);
    wait_intr(1'b1);
    ack(8'h0f, 2'h3);
    want[3] <= 1'b0;
    wrr(8'h22, 16'h8000);
    wait_intr(1'b0);
    // Cascade on pin zero only
    wrr(8'h38, 16'h0021);
    @(posedge clk);
    #1 chk({14'h0000, a1_oe, a0_oe}, 16'h0001);
    svec <= 8'h45;
    want[0] <= 1'b1;
    wait_intr(1'b1);
    ack(8'h45, 2'h2);
    wrr(8'h22, 16'h000c);
    want[0] <= 1'b0;
    // Nested override with cascade on pin one
    wrr(8'h3a, 16'h0061);
    svec <= 8'h71;
    want[1] <= 1'b1;
    wait_intr(1'b1);
    ack(8'h71, 2'h1);
    want[1] <= 1'b0;
    repeat (3) @(posedge clk);
    want[1] <= 1'b1;
    wait_intr(1'b1);
    ack(8'h71, 2'h1);
    rdc(8'h2c, 16'h0020);
    pulse(2'h1, 3'h0);
    repeat (3) @(posedge clk);
    #1 chk({15'h0000, intr}, 16'h0000);
    wrr(8'h22, 16'h8000);
    wait_intr(1'b1);
    rdc(8'h24, 16'h800a);
    results();
  end
endmodule : priority_interrupt_controller_tb

// ===== rtl/pic_pkg.sv
// Constants, types and register map of the priority interrupt controller
package pic_pkg;

  // Register offsets
  localparam logic [7:0] OFS_EOI    = 8'h22;
  localparam logic [7:0] OFS_POLL   = 8'h24;
  localparam logic [7:0] OFS_PSTAT  = 8'h26;
  localparam logic [7:0] OFS_MASK   = 8'h28;
  localparam logic [7:0] OFS_THRESH = 8'h2a;
  localparam logic [7:0] OFS_INSERV = 8'h2c;
  localparam logic [7:0] OFS_REQ    = 8'h2e;
  localparam logic [7:0] OFS_STAT   = 8'h30;
  // Control word offset per slot; slot 1 has no source
  localparam logic [7:0] CTL_OFS [8] = '{8'h32, 8'hff, 8'h34, 8'h36,
                                         8'h38, 8'h3a, 8'h3c, 8'h3e};

  // Slots: 0 timers, 2 dma0, 3 dma1, 4..7 external pins 0..3
  localparam logic [7:0] SLOT_USED = 8'hfd;
  localparam int         SLOT_TMR  = 0;
  localparam int         SLOT_DMA0 = 2;
  localparam int         SLOT_DMA1 = 3;
  localparam int         SLOT_EXT0 = 4;
  localparam int         SLOT_EXT1 = 5;

  // Fixed vector types per slot
  localparam logic [4:0] VEC_TYPE [8] = '{5'h08, 5'h00, 5'h0a, 5'h0b,
                                          5'h0c, 5'h0d, 5'h0e, 5'h0f};

  // Field positions
  localparam int B_INTREQ = 15;
  localparam int B_NSPEC  = 15;

  // Control word layout: pr[2:0], msk[3], ltm[4], cas[5], nested_override_mode[6]
  typedef struct packed {
    logic       nested_override_mode;
    logic       cas;
    logic       level_trigger_select;
    logic       msk;
    logic [2:0] pr;
  } ctl_t;

  // Writable control bits per slot
  localparam logic [6:0] CTL_WMASK [8] = '{7'h0f, 7'h00, 7'h0f, 7'h0f,
                                           7'h7f, 7'h7f, 7'h1f, 7'h1f};

  // Reset values
  localparam ctl_t       CTL_RST    = '{nested_override_mode: 1'b0, cas: 1'b0, level_trigger_select: 1'b0,
                                        msk: 1'b1, pr: 3'h7};
  localparam logic [2:0] THRESH_RST = 3'h7;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_WAIT = 2'b10
  } ack_st_t;

endpackage : pic_pkg

// ===== rtl/priority_interrupt_controller.sv
// Master-mode priority interrupt controller with poll and cascade support
// How it works
// - Cascade pairs: pin zero acked on pin two, pin one on pin three.
// - Each pair enters cascade by the cascade bit of its request control word.
// - A source with its in-service flag set raises no new request.
// - Nested override lets pin zero or one re-request; flag still blocks lower.
// - Poll word: bit 15 request pending, bits 4:0 winning vector type.
// - Reading the poll word sets the winner's in-service flag like an ack.
// - Poll status word mirrors poll word and changes no flag.
// - Each source has a 3-bit priority, lower is higher, default seven.
// - Ties at one level go to the lowest slot number.
// - Nonspecific end-of-service clears the highest-priority active flag.
// - Specific end-of-service clears only the flag of the written vector type.
// - Edge mode needs the pin sampled low before it requests again.
// - Level mode requests as long as the pin stays high.
// - Fixed vector types for timers, dma and direct external pins.
// - Cascaded ack takes two ack pulses; vector read from slave on the second.
// - Ack or poll sets the flag; lower priorities then stay held back.
// - In-service flags: one for timers, one per dma, one per pin; read/write.
// - Timer request is OR of timers; internal bits set on event; an ack clears the dma bit or the lowest set timer bit.
// - External request bits are live, read-only, edge mode shows armed rise.
// - Mask register bits are the same storage as control word mask bits.
// - Priority threshold blocks higher numbers than its code; resets to seven.
// - Trigger bit one selects level, zero selects edge.
//
// Local design decisions: the register addresses and strobed register access.
module priority_interrupt_controller
  import pic_pkg::*;
(
  // Clock and reset
  input  wire logic        CLOCK_I,
  input  wire logic        ARST_N_I,
  // Register port
  input  wire logic [7:0]  ADDR_I,
  input  wire logic [15:0] WDATA_I,
  input  wire logic        WR_I,
  input  wire logic        RD_I,
  output logic      [15:0] RDATA_O,
  // Internal sources, one-cycle events
  input  wire logic [2:0]  TIMER_REQ_I,
  input  wire logic [1:0]  DMA_REQ_I,
  // CPU side
  input  wire logic        INTA_I,
  output logic             INTR_O,
  output logic      [7:0]  VECTOR_O,
  output logic             VECTOR_VALID_O,
  // External pins
  input  wire logic        EXT_REQUEST_ZERO_I,
  input  wire logic        EXT_REQUEST_ONE_I,
  input  wire logic        EXT_PIN_TWO_OR_ACK_ZERO_I,
  output logic             EXT_PIN_TWO_OR_ACK_ZERO_O,
  output logic             EXT_PIN_TWO_OR_ACK_ZERO_OE_O,
  input  wire logic        EXT_PIN_THREE_OR_ACK_ONE_I,
  output logic             EXT_PIN_THREE_OR_ACK_ONE_O,
  output logic             EXT_PIN_THREE_OR_ACK_ONE_OE_O,
  input  wire logic [7:0]  CAS_VECTOR_I
);

  ////////////////////////////////////////////////////////////////////////////

  function automatic logic [3:0] pick_best(input logic [7:0] cand,
                                           input ctl_t c [8]);
    logic [3:0] r;
    r = 4'h0;
    for (int i = 0; i < 8; i++) begin
      if (cand[i] && (!r[3] || c[i].pr < c[r[2:0]].pr)) begin
        r = {1'b1, 3'(i)};
      end
    end
    return r;
  endfunction : pick_best

  function automatic logic [3:0] ctl_hit(input logic [7:0] a);
    logic [3:0] r;
    r = 4'h0;
    for (int i = 0; i < 8; i++) begin
      if (SLOT_USED[i] && a == CTL_OFS[i]) begin
        r = {1'b1, 3'(i)};
      end
    end
    return r;
  endfunction : ctl_hit

  function automatic logic [3:0] vec_to_slot(input logic [4:0] v);
    logic [3:0] r;
    r = 4'h0;
    for (int i = 0; i < 8; i++) begin
      if (SLOT_USED[i] && v == VEC_TYPE[i]) begin
        r = {1'b1, 3'(i)};
      end
    end
    return r;
  endfunction : vec_to_slot
  ////////////////////////////////////////////////////////////////////////////

  ctl_t       ctl_ff [8];
  ctl_t       nxt_ctl [8];
  logic [2:0] thr_ff, nxt_thr;
  logic [7:0] isr_ff, nxt_isr;
  logic [2:0] irt_ff, nxt_irt;
  logic [1:0] dma_ff, nxt_dma;
  logic [3:0] arm_ff, nxt_arm;
  logic [3:0] sy1_ff, sy2_ff;
  logic [7:0] cv1_ff, cv2_ff;
  ack_st_t    st_ff, nxt_st;
  logic [2:0] slot_ff, nxt_slot;
  logic [7:0] vec_ff, nxt_vec;
  logic       vval_ff, nxt_vval;
  logic [15:0] rd_ff, nxt_rd;

  logic [3:0] ext_live;
  logic [7:0] req_vec, ovr, elig;
  logic [3:0] win, isw, hit, eoi_s;
  logic       req_ok, take, poll_rd, is_casc;
  logic [15:0] poll_val;

  default clocking cb @(posedge CLOCK_I); endclocking
  default disable iff (!ARST_N_I);

  ////////////////////////////////////////////////////////////////////////////
  // Request sources and resolution
  always_comb begin
    for (int k = 0; k < 4; k++) begin
      ext_live[k] = sy2_ff[k] & (ctl_ff[SLOT_EXT0 + k].level_trigger_select | arm_ff[k]);
    end
    // pins two and three become acks
    ext_live[2] = ext_live[2] & ~ctl_ff[SLOT_EXT0].cas;
    ext_live[3] = ext_live[3] & ~ctl_ff[SLOT_EXT1].cas;
    // timer bit is OR of timers
    req_vec = {ext_live, dma_ff, 1'b0, |irt_ff};
    for (int i = 0; i < 8; i++) begin
      // override on pins zero and one
      ovr[i] = (i == SLOT_EXT0 || i == SLOT_EXT1) && ctl_ff[i].nested_override_mode;
      elig[i] = req_vec[i] & ~ctl_ff[i].msk & (ctl_ff[i].pr <= thr_ff)
                & (~isr_ff[i] | ovr[i]);
    end
    win = pick_best(elig, ctl_ff);
    isw = pick_best(isr_ff, ctl_ff);
    req_ok = win[3] && (!isw[3]
             || ctl_ff[win[2:0]].pr < ctl_ff[isw[2:0]].pr
             || (ovr[win[2:0]] && ctl_ff[win[2:0]].pr <= ctl_ff[isw[2:0]].pr));
    poll_val = {req_ok, 10'h000, VEC_TYPE[win[2:0]]};
    poll_rd = RD_I && ADDR_I == OFS_POLL;
    take = req_ok && ((st_ff == ST_IDLE && INTA_I) || poll_rd);
  end

  masked_never_a: assert property (req_ok |-> !ctl_ff[win[2:0]].msk)
    else $error("masked source forwarded");
  thresh_gate_a: assert property (req_ok |-> ctl_ff[win[2:0]].pr <= thr_ff)
    else $error("threshold ignored");
  level_cont_a: assert property (
    ctl_ff[SLOT_EXT0 + 3].level_trigger_select && sy2_ff[3] && !ctl_ff[SLOT_EXT1].cas |-> req_vec[SLOT_EXT0 + 3])
    else $error("level request dropped");
  // no second edge request without low
  edge_rearm_a: assert property (
    take && win[2:0] == 3'(SLOT_EXT0) && !ctl_ff[SLOT_EXT0].level_trigger_select
    |=> !req_vec[SLOT_EXT0])
    else $error("edge input re-requested");

  ////////////////////////////////////////////////////////////////////////////
  // Internal request latches, edge arming, synchronisers
  always_comb begin
    nxt_irt = irt_ff;
    nxt_dma = dma_ff;
    nxt_arm = arm_ff;
    if (WR_I && ADDR_I == OFS_STAT) begin
      nxt_irt = WDATA_I[2:0];
    end
    if (WR_I && ADDR_I == OFS_REQ) begin
      nxt_dma = WDATA_I[3:2];
    end
    if (take) begin
      unique case (win[2:0])
        3'(SLOT_TMR):  nxt_irt = irt_ff[0] ? {irt_ff[2:1], 1'b0} :
                                 irt_ff[1] ? {irt_ff[2], 2'b00} : 3'h0;
        3'(SLOT_DMA0): nxt_dma[0] = 1'b0;
        3'(SLOT_DMA1): nxt_dma[1] = 1'b0;
        default:       nxt_arm[win[1:0]] = 1'b0;
      endcase
    end
    // New events win over any clear
    nxt_irt = nxt_irt | TIMER_REQ_I;
    nxt_dma = nxt_dma | DMA_REQ_I;
    nxt_arm = nxt_arm | ~sy2_ff;
  end

  always_ff @(posedge CLOCK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      irt_ff <= 3'h0;
      dma_ff <= 2'h0;
      arm_ff <= 4'h0;
      sy1_ff <= 4'h0;
      sy2_ff <= 4'h0;
      cv1_ff <= 8'h00;
      cv2_ff <= 8'h00;
    end else begin
      irt_ff <= nxt_irt;
      dma_ff <= nxt_dma;
      arm_ff <= nxt_arm;
      sy1_ff <= {EXT_PIN_THREE_OR_ACK_ONE_I, EXT_PIN_TWO_OR_ACK_ZERO_I,
                 EXT_REQUEST_ONE_I, EXT_REQUEST_ZERO_I};
      sy2_ff <= sy1_ff;
      cv1_ff <= CAS_VECTOR_I;
      cv2_ff <= cv1_ff;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control words, threshold, in-service flags
  always_comb begin
    hit   = ctl_hit(ADDR_I);
    eoi_s = WDATA_I[B_NSPEC] ? isw : vec_to_slot(WDATA_I[4:0]);
    nxt_thr = thr_ff;
    nxt_isr = isr_ff;
    for (int i = 0; i < 8; i++) begin
      nxt_ctl[i] = ctl_ff[i];
    end
    if (WR_I && hit[3]) begin
      nxt_ctl[hit[2:0]] = ctl_t'(WDATA_I[6:0] & CTL_WMASK[hit[2:0]]);
    end
    if (WR_I && ADDR_I == OFS_MASK) begin
      for (int i = 0; i < 8; i++) begin
        if (SLOT_USED[i]) begin
          nxt_ctl[i].msk = WDATA_I[i];
        end
      end
    end
    if (WR_I && ADDR_I == OFS_THRESH) begin
      nxt_thr = WDATA_I[2:0];
    end
    if (WR_I && ADDR_I == OFS_INSERV) begin
      nxt_isr = WDATA_I[7:0] & SLOT_USED;
    end
    if (WR_I && ADDR_I == OFS_EOI && eoi_s[3]) begin
      nxt_isr[eoi_s[2:0]] = 1'b0;
    end
    // ack or poll sets flag, wins over clear
    if (take) begin
      nxt_isr[win[2:0]] = 1'b1;
    end
  end

  always_ff @(posedge CLOCK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      for (int i = 0; i < 8; i++) begin
        ctl_ff[i] <= CTL_RST;
      end
      thr_ff <= THRESH_RST;
      isr_ff <= 8'h00;
    end else begin
      ctl_ff <= nxt_ctl;
      thr_ff <= nxt_thr;
      isr_ff <= nxt_isr;
    end
  end

  poll_sets_a: assert property (poll_rd && req_ok |=> isr_ff[$past(win[2:0])])
    else $error("poll did not set flag");
  nspec_clear_a: assert property (
    WR_I && ADDR_I == OFS_EOI && WDATA_I[B_NSPEC] && isw[3] && !take
    |=> !isr_ff[$past(isw[2:0])])
    else $error("nonspecific clear missed");
  pstat_keep_a: assert property (
    RD_I && ADDR_I == OFS_PSTAT && !INTA_I |=> isr_ff == $past(isr_ff))
    else $error("status read changed flags");

  ////////////////////////////////////////////////////////////////////////////
  // Acknowledge sequence
  always_comb begin
    nxt_st   = st_ff;
    nxt_slot = slot_ff;
    nxt_vec  = vec_ff;
    nxt_vval = 1'b0;
    is_casc  = (slot_ff == 3'(SLOT_EXT0) && ctl_ff[SLOT_EXT0].cas)
               || (slot_ff == 3'(SLOT_EXT1) && ctl_ff[SLOT_EXT1].cas);
    // two ack pulses, vector on the second
    unique case (st_ff)
      ST_IDLE: begin
        if (INTA_I && req_ok) begin
          nxt_slot = win[2:0];
          nxt_st   = ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (INTA_I) begin
          nxt_vec  = is_casc ? cv2_ff : {3'h0, VEC_TYPE[slot_ff]};
          nxt_vval = 1'b1;
          nxt_st   = ST_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge CLOCK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      st_ff   <= ST_IDLE;
      slot_ff <= 3'h0;
      vec_ff  <= 8'h00;
      vval_ff <= 1'b0;
    end else begin
      st_ff   <= nxt_st;
      slot_ff <= nxt_slot;
      vec_ff  <= nxt_vec;
      vval_ff <= nxt_vval;
    end
  end

  // each pair drives its ack only in cascade
  // ack low from after the first ack pulse through the second
  assign EXT_PIN_TWO_OR_ACK_ZERO_OE_O   = ctl_ff[SLOT_EXT0].cas;
  assign EXT_PIN_THREE_OR_ACK_ONE_OE_O  = ctl_ff[SLOT_EXT1].cas;
  assign EXT_PIN_TWO_OR_ACK_ZERO_O      = !(st_ff == ST_WAIT
                                            && slot_ff == 3'(SLOT_EXT0));
  assign EXT_PIN_THREE_OR_ACK_ONE_O     = !(st_ff == ST_WAIT
                                            && slot_ff == 3'(SLOT_EXT1));
  assign INTR_O         = req_ok;
  assign VECTOR_O       = vec_ff;
  assign VECTOR_VALID_O = vval_ff;

  // pin zero ack drives pin two
  ack_pin_a: assert property (
    st_ff == ST_WAIT && slot_ff == 3'(SLOT_EXT0) |-> !EXT_PIN_TWO_OR_ACK_ZERO_O)
    else $error("cascade ack not driven");
  vec_timing_a: assert property (
    st_ff == ST_WAIT && INTA_I |=> VECTOR_VALID_O && st_ff == ST_IDLE)
    else $error("vector not delivered");

  ////////////////////////////////////////////////////////////////////////////
  // Read port, data one cycle after strobe

  always_comb begin
    nxt_rd = 16'h0000;
    if (RD_I) begin
      if (hit[3]) begin
        nxt_rd = {9'h000, ctl_ff[hit[2:0]]};
      end
      unique case (ADDR_I)
        OFS_POLL, OFS_PSTAT: nxt_rd = poll_val;
        OFS_THRESH: nxt_rd = {13'h0000, thr_ff};
        OFS_INSERV: nxt_rd = {8'h00, isr_ff};
        OFS_REQ:    nxt_rd = {8'h00, req_vec};
        OFS_STAT:   nxt_rd = {13'h0000, irt_ff};
        OFS_MASK: begin
          for (int i = 0; i < 8; i++) begin
            nxt_rd[i] = SLOT_USED[i] & ctl_ff[i].msk;
          end
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge CLOCK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      rd_ff <= 16'h0000;
    end else begin
      rd_ff <= nxt_rd;
    end
  end

  assign RDATA_O = rd_ff;

  poll_format_a: assert property (
    poll_rd |=> RDATA_O == {$past(req_ok), 10'h000, $past(VEC_TYPE[win[2:0]])})
    else $error("poll word wrong");

endmodule : priority_interrupt_controller
